// *** rtl/vpl_pkg.sv ***
package vpl_pkg;

	// register addresses as printed; the status, mask and reference words sit after them
	localparam logic [15:0] ADDR_ACCEL      = 16'h2206;
	localparam logic [15:0] ADDR_DECEL      = 16'h2207;
	localparam logic [15:0] ADDR_SCURVE     = 16'h2208;
	localparam logic [15:0] ADDR_LIMIT      = 16'h2210;
	localparam logic [15:0] ADDR_MODE       = 16'h2211;
	localparam logic [15:0] ADDR_REF        = 16'h2212;
	localparam logic [15:0] ADDR_STATUS     = 16'h2213;
	localparam logic [15:0] ADDR_MASK       = 16'h2214;

	localparam logic [31:0] RST_ACCEL       = 32'h0000_a2c3;
	localparam logic [31:0] RST_DECEL       = 32'h0000_a2c3;
	localparam logic [15:0] RST_SCURVE      = 16'h0000;
	localparam logic [15:0] RST_LIMIT       = 16'h1388;
	localparam logic [7:0]  RST_MODE        = 8'h00;

	localparam logic [31:0] RATE_MAX        = 32'h7fff_ffff;
	localparam logic [15:0] SCURVE_MAX      = 16'h1388;
	localparam logic [15:0] LIMIT_MAX       = 16'h1770;

	// status and mask bit positions
	localparam int          ST_VLIMIT       = 0;
	localparam int          ST_SETTLED      = 1;
	localparam int          ST_REFUSED      = 2;
	localparam int          ST_W            = 3;

	// timing: 100 MHz clock, reference stepped once per control period
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          CTRL_PERIOD_NS  = 1000;
	localparam int          CTRL_CYCLES     = CTRL_PERIOD_NS / CLK_PERIOD_NS;
	localparam int          NS_PER_MS       = 1000000;
	localparam int          PERIODS_PER_MS  = NS_PER_MS / CTRL_PERIOD_NS;

	// rate in 0.01 rev/s^2 to rpm with 32 fraction bits per period: rate * 0.6 * period_s * 2^32
	localparam logic [63:0] RATE_SCALE      = (64'd6 * (64'd1 << 32) * 64'(CTRL_PERIOD_NS)) / 64'd10000000000;
	localparam int          FRAC_W          = 32;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        load;
		logic [15:0] max_speed;
	} motor_sel_t;

endpackage : vpl_pkg

// *** rtl/jerk_divider.sv ***
`timescale 1ns/1ps

// restoring serial divider, one quotient bit per clock
module jerk_divider #(
	parameter int W = 64
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         start,
	input  wire logic [W-1:0] dividend,
	input  wire logic [W-1:0] divisor,
	output logic              busy,
	output logic              done,
	output logic [W-1:0]      quotient
);

	initial begin
		if (W < 8) $error("jerk_divider width too small");
	end

	logic [W-1:0]         rem;
	logic [W-1:0]         quo;
	logic [W-1:0]         den;
	logic [$clog2(W):0]   cnt;
	logic [W:0]           trial;

	assign trial = {rem, quo[W-1]} - {1'b0, den};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rem      <= '0;
			quo      <= '0;
			den      <= '0;
			cnt      <= '0;
			busy     <= 1'b0;
			done     <= 1'b0;
			quotient <= '0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				rem  <= '0;
				quo  <= dividend;
				den  <= (divisor == '0) ? W'(1) : divisor;
				cnt  <= ($clog2(W)+1)'(W);
				busy <= 1'b1;
			end else if (busy) begin
				if (!trial[W]) begin
					rem <= trial[W-1:0];
					quo <= {quo[W-2:0], 1'b1};
				end else begin
					rem <= {rem[W-2:0], quo[W-1]};
					quo <= {quo[W-2:0], 1'b0};
				end
				cnt <= cnt - 1'b1;
				if (cnt == ($clog2(W)+1)'(1)) begin
					busy     <= 1'b0;
					done     <= 1'b1;
					quotient <= trial[W] ? {quo[W-2:0], 1'b0} : {quo[W-2:0], 1'b1};
				end
			end
		end
	end

endmodule : jerk_divider

// *** rtl/velocity_profile_limiter.sv ***
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

// Behaviour
// - a rising speed moves at the programmed acceleration rate, 1 to 2147483647, reset 41667.
// - a falling speed moves at the separate deceleration rate with the same range and reset.
// - each ramp has its start and end rounded over the S-curve time of 0 to 5000 ms, reset 0.
// - an S-curve time of zero gives plain linear ramps.
// - S-curve rounding only shapes the ramp rates and never acts without them.
// - a shaped profile lasts longer than the raw command by the ramp time plus the S-curve time.
// - with limiting on, the ramp target never exceeds the speed limit whatever the command; a reference above a lowered limit ramps down to it.
// - the speed limit is a 16-bit value, 1 to 6000, reset 5000.
// - selecting a motor loads the speed limit with that motor's maximum speed when it lies in 1 to 6000; other values are ignored.
// - the velocity-limit indication is high while motor speed is at or above the limit with limiting on.
// - limit mode bit 0 off disables limiting, on enables it, reset off.
module velocity_profile_limiter #(
	parameter int CTRL_CYCLES_P = vpl_pkg::CTRL_CYCLES
) (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire vpl_pkg::reg_req_t    req,
	output logic [31:0]               rdata,
	input  wire vpl_pkg::motor_sel_t  motor_sel,
	input  wire logic signed [15:0]   speed_cmd,
	input  wire logic signed [15:0]   motor_speed,
	output logic signed [15:0]        speed_ref,
	output logic                      velocity_limit_indication,
	output logic                      irq
);

	initial begin
		if (CTRL_CYCLES_P < 2) $error("control period too short");
	end

	function automatic logic [15:0] mag16(input logic signed [15:0] v);
		return v[15] ? 16'(-v) : 16'(v);
	endfunction : mag16

	function automatic logic [63:0] mag64(input logic signed [63:0] v);
		return v[63] ? 64'(-v) : 64'(v);
	endfunction : mag64

	localparam int ST_W = vpl_pkg::ST_W;

	logic [31:0]               accel_rate;
	logic [31:0]               decel_rate;
	logic [15:0]               scurve_duration;
	logic [15:0]               speed_limit_value;
	logic [7:0]                speed_limit_mode;
	logic [ST_W-1:0]           status;
	logic [ST_W-1:0]           mask;
	logic                      limit_mode_select;
	logic                      refused;
	logic                      status_rd;

	assign limit_mode_select = speed_limit_mode[0];

	// register writes; out-of-range values are refused and flagged
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			accel_rate        <= vpl_pkg::RST_ACCEL;
			decel_rate        <= vpl_pkg::RST_DECEL;
			scurve_duration   <= vpl_pkg::RST_SCURVE;
			speed_limit_value <= vpl_pkg::RST_LIMIT;
			speed_limit_mode  <= vpl_pkg::RST_MODE;
			refused           <= 1'b0;
		end else begin
			refused <= 1'b0;
			if (req.wr) begin
				unique case (req.addr)
					vpl_pkg::ADDR_ACCEL: begin
						if (req.wdata != 32'h0 && req.wdata <= vpl_pkg::RATE_MAX) accel_rate <= req.wdata;
						else refused <= 1'b1;
					end
					vpl_pkg::ADDR_DECEL: begin
						if (req.wdata != 32'h0 && req.wdata <= vpl_pkg::RATE_MAX) decel_rate <= req.wdata;
						else refused <= 1'b1;
					end
					vpl_pkg::ADDR_SCURVE: begin
						if (req.wdata[31:16] == 16'h0 && req.wdata[15:0] <= vpl_pkg::SCURVE_MAX)
							scurve_duration <= req.wdata[15:0];
						else refused <= 1'b1;
					end
					vpl_pkg::ADDR_LIMIT: begin
						if (req.wdata[31:16] == 16'h0 && req.wdata[15:0] != 16'h0 &&
						    req.wdata[15:0] <= vpl_pkg::LIMIT_MAX)
							speed_limit_value <= req.wdata[15:0];
						else refused <= 1'b1;
					end
					vpl_pkg::ADDR_MODE: speed_limit_mode <= {7'h0, req.wdata[0]};
					default: ;
				endcase
			end
			// motor selection overrides a same-cycle software write of the limit
			if (motor_sel.load && motor_sel.max_speed != 16'h0 && motor_sel.max_speed <= vpl_pkg::LIMIT_MAX)
				speed_limit_value <= motor_sel.max_speed;
		end
	end

	a_limit_range: assert property (@(posedge clk) disable iff (!resetn)
		speed_limit_value != 16'h0 && speed_limit_value <= vpl_pkg::LIMIT_MAX)
		else $error("speed limit out of range");

	a_motor_load: assert property (@(posedge clk) disable iff (!resetn)
		motor_sel.load && motor_sel.max_speed != 16'h0 && motor_sel.max_speed <= vpl_pkg::LIMIT_MAX
		|=> speed_limit_value == $past(motor_sel.max_speed))
		else $error("motor max speed not loaded");

	a_rate_guard: assert property (@(posedge clk) disable iff (!resetn)
		req.wr && req.addr == vpl_pkg::ADDR_ACCEL && req.wdata == 32'h0 |=> $stable(accel_rate) && refused)
		else $error("zero acceleration accepted");

	a_refused_flag: assert property (@(posedge clk) disable iff (!resetn)
		req.wr && req.addr == vpl_pkg::ADDR_LIMIT && !motor_sel.load &&
		(req.wdata == 32'h0 || req.wdata > 32'(vpl_pkg::LIMIT_MAX)) |=> $stable(speed_limit_value) && refused)
		else $error("bad speed limit accepted");

	// control period tick
	logic [$clog2(CTRL_CYCLES_P)-1:0] tick_cnt;
	logic                             tick;

	assign tick = (tick_cnt == '0);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) tick_cnt <= '0;
		else if (tick) tick_cnt <= ($clog2(CTRL_CYCLES_P))'(CTRL_CYCLES_P - 1);
		else tick_cnt <= tick_cnt - 1'b1;
	end

	// target: command clamped to the limit while limiting is on
	logic signed [15:0] target;
	logic [15:0]        cmd_mag;

	always_comb begin
		cmd_mag = mag16(speed_cmd);
		target  = speed_cmd;
		if (limit_mode_select && cmd_mag > speed_limit_value)
			target = speed_cmd[15] ? 16'(-speed_limit_value) : speed_limit_value;
	end

	a_target_clamp: assert property (@(posedge clk) disable iff (!resetn)
		limit_mode_select |-> mag16(target) <= speed_limit_value)
		else $error("target above speed limit");

	// fixed-point reference, 32 fraction bits below the rpm value
	logic signed [63:0] ref_acc;
	logic signed [63:0] tgt_acc;
	logic signed [63:0] err;
	logic [63:0]        err_mag;
	logic               rising;
	logic [63:0]        step_full;
	logic [63:0]        accel_step;
	logic [63:0]        decel_step;
	logic [63:0]        accel_jerk;
	logic [63:0]        decel_jerk;
	logic [63:0]        jerk;
	logic [63:0]        lvl;
	logic [63:0]        dist_up;
	logic [63:0]        step;
	logic [63:0]        next_lvl;
	logic [63:0]        next_dist_up;

	assign tgt_acc    = {{16{target[15]}}, target, 32'h0};
	assign err        = tgt_acc - ref_acc;
	assign err_mag    = mag64(err);
	// rising magnitude with no sign reversal uses acceleration
	assign rising     = (ref_acc == 64'sh0) || ((err[63] == ref_acc[63]) && err != 64'sh0);
	assign accel_step = 64'(accel_rate) * vpl_pkg::RATE_SCALE;
	assign decel_step = 64'(decel_rate) * vpl_pkg::RATE_SCALE;
	assign step_full  = rising ? accel_step : decel_step;
	assign jerk       = rising ? accel_jerk : decel_jerk;

	// s-curve: the step level climbs by jerk, and mirrors down once the remaining error
	// reaches the distance covered while climbing
	always_comb begin
		next_lvl     = lvl;
		next_dist_up = dist_up;
		step         = step_full;
		if (err_mag == 64'h0) begin
			next_lvl     = 64'h0;
			next_dist_up = 64'h0;
		end else if (scurve_duration == 16'h0) begin
			step = step_full;
		end else begin
			if (err_mag <= dist_up && lvl > jerk) begin
				next_lvl     = lvl - jerk;
				next_dist_up = (dist_up > lvl) ? dist_up - lvl : 64'h0;
			end else if (lvl < step_full) begin
				next_lvl     = (step_full - lvl > jerk) ? lvl + jerk : step_full;
				next_dist_up = dist_up + next_lvl;
			end else if (lvl > step_full) begin
				next_lvl = step_full;
			end
			step = (next_lvl == 64'h0) ? jerk : next_lvl;
		end
		if (step > err_mag) step = err_mag;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ref_acc <= 64'sh0;
			lvl     <= 64'h0;
			dist_up <= 64'h0;
		end else if (tick) begin
			ref_acc <= err[63] ? ref_acc - $signed(step) : ref_acc + $signed(step);
			lvl     <= next_lvl;
			dist_up <= next_dist_up;
		end
	end

	assign speed_ref = ref_acc[vpl_pkg::FRAC_W +: 16];

	a_step_tick: assert property (@(posedge clk) disable iff (!resetn)
		!tick |=> $stable(ref_acc))
		else $error("reference moved between control periods");

	a_linear_step: assert property (@(posedge clk) disable iff (!resetn)
		tick && scurve_duration == 16'h0 && err_mag > step_full
		|=> mag64($signed(ref_acc - $past(ref_acc))) == $past(step_full))
		else $error("linear ramp step wrong");

	a_scurve_soft: assert property (@(posedge clk) disable iff (!resetn)
		tick && scurve_duration != 16'h0 && lvl == 64'h0 && err_mag > jerk
		|=> mag64($signed(ref_acc - $past(ref_acc))) <= $past(jerk))
		else $error("s-curve start not rounded");

	// jerk = full step / s-curve periods, both rates served by one divider in turn
	logic        div_start;
	logic        div_busy;
	logic        div_done;
	logic [63:0] div_q;
	logic        div_sel;
	logic [63:0] scurve_periods;

	assign scurve_periods = 64'(scurve_duration) * 64'(vpl_pkg::PERIODS_PER_MS);
	assign div_start      = !div_busy && !div_done;

	jerk_divider #(
		.W (64)
	) u_div (
		.clk      (clk),
		.resetn   (resetn),
		.start    (div_start),
		.dividend (div_sel ? decel_step : accel_step),
		.divisor  (scurve_periods),
		.busy     (div_busy),
		.done     (div_done),
		.quotient (div_q)
	);

	// a zero quotient is lifted to one so a long s-curve never stalls the ramp
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			accel_jerk <= 64'h1;
			decel_jerk <= 64'h1;
			div_sel    <= 1'b0;
		end else if (div_done) begin
			if (div_sel) decel_jerk <= (div_q == 64'h0) ? 64'h1 : div_q;
			else accel_jerk <= (div_q == 64'h0) ? 64'h1 : div_q;
			div_sel <= !div_sel;
		end
	end

	// velocity-limit indication from measured speed
	logic vlimit_now;

	assign vlimit_now = limit_mode_select && (mag16(motor_speed) >= speed_limit_value);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) velocity_limit_indication <= 1'b0;
		else velocity_limit_indication <= vlimit_now;
	end

	a_vlimit_ind: assert property (@(posedge clk) disable iff (!resetn)
		##1 velocity_limit_indication == $past(limit_mode_select && mag16(motor_speed) >= speed_limit_value))
		else $error("velocity-limit indication wrong");

	a_mode_off: assert property (@(posedge clk) disable iff (!resetn)
		!limit_mode_select ##1 !limit_mode_select |-> !velocity_limit_indication && target == speed_cmd)
		else $error("limiting active while disabled");

	// sticky status: set wins over the read that clears it
	logic       vlimit_q;
	logic       settled_q;
	logic       settled_now;
	logic [ST_W-1:0] events;

	assign settled_now = (err == 64'sh0);
	assign status_rd   = req.rd && req.addr == vpl_pkg::ADDR_STATUS;

	always_comb begin
		events = '0;
		events[vpl_pkg::ST_VLIMIT]  = vlimit_now && !vlimit_q;
		events[vpl_pkg::ST_SETTLED] = settled_now && !settled_q;
		events[vpl_pkg::ST_REFUSED] = refused;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vlimit_q  <= 1'b0;
			settled_q <= 1'b1;
			status    <= '0;
		end else begin
			vlimit_q  <= vlimit_now;
			settled_q <= settled_now;
			status    <= (status_rd ? '0 : status) | events;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) mask <= '0;
		else if (req.wr && req.addr == vpl_pkg::ADDR_MASK) mask <= req.wdata[ST_W-1:0];
	end

	assign irq = |(status & mask);

	a_status_sticky: assert property (@(posedge clk) disable iff (!resetn)
		events[vpl_pkg::ST_VLIMIT] |=> status[vpl_pkg::ST_VLIMIT])
		else $error("event lost from status");

	// a read with no event in the same cycle must leave nothing behind
	a_status_read: assert property (@(posedge clk) disable iff (!resetn)
		status_rd && events == '0 |=> status == '0)
		else $error("status not cleared by read");

	// read data, valid the cycle after the strobe only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) rdata <= 32'h0;
		else if (req.rd) begin
			unique case (req.addr)
				vpl_pkg::ADDR_ACCEL:  rdata <= accel_rate;
				vpl_pkg::ADDR_DECEL:  rdata <= decel_rate;
				vpl_pkg::ADDR_SCURVE: rdata <= {16'h0, scurve_duration};
				vpl_pkg::ADDR_LIMIT:  rdata <= {16'h0, speed_limit_value};
				vpl_pkg::ADDR_MODE:   rdata <= {24'h0, speed_limit_mode};
				vpl_pkg::ADDR_REF:    rdata <= {{16{speed_ref[15]}}, speed_ref};
				vpl_pkg::ADDR_STATUS: rdata <= {{(32-ST_W){1'b0}}, status};
				vpl_pkg::ADDR_MASK:   rdata <= {{(32-ST_W){1'b0}}, mask};
				default:              rdata <= 32'h0;
			endcase
		end else rdata <= 32'h0;
	end

endmodule : velocity_profile_limiter

// *** tb/host_ctrl_model.sv ***
`timescale 1ns/1ps

// host controller issuing the speed command; also stands in for the motor
module host_ctrl_model (
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic signed [15:0] cmd_level,
	input  wire logic               ovr_en,
	input  wire logic signed [15:0] ovr_speed,
	input  wire logic signed [15:0] speed_ref,
	input  wire logic               velocity_limit_indication,
	output logic signed [15:0]      speed_cmd,
	output logic signed [15:0]      motor_speed,
	output logic                    seq_out_vlimit
);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			speed_cmd   <= 16'sh0000;
			motor_speed <= 16'sh0000;
		end else begin
			speed_cmd   <= cmd_level;
			// ideal motor tracks the reference; override lets the bench pin the speed
			motor_speed <= ovr_en ? ovr_speed : speed_ref;
		end
	end

	// indication is only visible once routed to a sequence output
	assign seq_out_vlimit = velocity_limit_indication;
endmodule : host_ctrl_model

// *** tb/velocity_profile_limiter_tb.sv ***
`timescale 1ns/1ps

module velocity_profile_limiter_tb;
	localparam int          CT  = 4;
	localparam logic [31:0] ACC = 32'h1000_0000; // exactly 161 rpm per period
	localparam logic [31:0] DEC = 32'h2000_0000; // exactly 322 rpm per period

	logic                clk;
	logic                resetn;
	vpl_pkg::reg_req_t   req;
	logic [31:0]         rdata;
	vpl_pkg::motor_sel_t motor_sel;
	logic signed [15:0]  speed_cmd;
	logic signed [15:0]  motor_speed;
	logic signed [15:0]  speed_ref;
	logic                velocity_limit_indication;
	logic                irq;
	logic signed [15:0]  cmd_level;
	logic                ovr_en;
	logic signed [15:0]  ovr_speed;
	logic                seq_out_vlimit;
	logic [31:0]         d;
	int                  err_total;
	int                  compares;
	int                  cycles;
	int                  n_cyc;
	int                  max_step;
	int                  first_step;
	logic [15:0]         bad_a [7];
	logic [31:0]         bad_v [7];
	logic [31:0]         keep_v [7];

	velocity_profile_limiter #(.CTRL_CYCLES_P(CT)) dut_u (
		.clk                       (clk),
		.resetn                    (resetn),
		.req                       (req),
		.rdata                     (rdata),
		.motor_sel                 (motor_sel),
		.speed_cmd                 (speed_cmd),
		.motor_speed               (motor_speed),
		.speed_ref                 (speed_ref),
		.velocity_limit_indication (velocity_limit_indication),
		.irq                       (irq)
	);

	host_ctrl_model host_u (
		.clk                       (clk),
		.resetn                    (resetn),
		.cmd_level                 (cmd_level),
		.ovr_en                    (ovr_en),
		.ovr_speed                 (ovr_speed),
		.speed_ref                 (speed_ref),
		.velocity_limit_indication (velocity_limit_indication),
		.speed_cmd                 (speed_cmd),
		.motor_speed               (motor_speed),
		.seq_out_vlimit            (seq_out_vlimit)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_total++;
			wrap_up();
		end
	end

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk32

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		chk32({16'h0000, got}, {16'h0000, exp});
	endtask : chk16

	task automatic chk1(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask : chk1

	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk);
		req <= '0;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [31:0] v);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
		@(posedge clk);
		req <= '0;
		#1;
		v = rdata;
	endtask : rd

	task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		chk32(v, exp);
	endtask : rchk

	// follows the reference until it settles; optionally checks each step and its spacing
	task automatic follow(input int tgt, input bit steps);
		int prev;
		int gap;
		int st;
		int mag;
		int n_chg;
		prev = int'(speed_ref);
		gap = 0;
		n_chg = 0;
		n_cyc = 0;
		max_step = 0;
		first_step = 0;
		while (speed_ref !== 16'(tgt) && n_cyc < 3000) begin
			@(posedge clk);
			#1;
			n_cyc++;
			gap++;
			if (speed_ref !== 16'(prev)) begin
				st = int'(speed_ref) - prev;
				mag = (st < 0) ? -st : st;
				if (n_chg == 0)
					first_step = mag;
				if (mag > max_step)
					max_step = mag;
				if (steps) begin
					mag = ((tgt > prev && prev >= 0) || (tgt < prev && prev <= 0)) ? 161 : 322;
					chk16(speed_ref, 16'((tgt > prev + mag) ? prev + mag : (tgt < prev - mag) ? prev - mag : tgt));
					if (n_chg > 0)
						chk32(32'(gap), 32'(CT));
				end
				n_chg++;
				gap = 0;
				prev = int'(speed_ref);
			end
		end
		chk16(speed_ref, 16'(tgt));
	endtask : follow

	task automatic pins(input logic [15:0] sp);
		ovr_speed <= sp;
		repeat (3) @(posedge clk);
		#1;
	endtask : pins

	task automatic wrap_up();
		$display("counts: compares=%0d mismatches=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	initial begin
		bad_a = '{vpl_pkg::ADDR_ACCEL, vpl_pkg::ADDR_ACCEL, vpl_pkg::ADDR_DECEL, vpl_pkg::ADDR_DECEL,
			vpl_pkg::ADDR_SCURVE, vpl_pkg::ADDR_LIMIT, vpl_pkg::ADDR_LIMIT};
		bad_v = '{32'h0, 32'h8000_0000, 32'h0, 32'h8000_0000, 32'h1389, 32'h0, 32'h1771};
		keep_v = '{32'ha2c3, 32'ha2c3, 32'ha2c3, 32'ha2c3, 32'h0, 32'h1388, 32'h1388};
		resetn = 1'b0;
		req = '0;
		motor_sel = '0;
		cmd_level = 16'sh0000;
		ovr_en = 1'b0;
		ovr_speed = 16'sh0000;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		rchk(vpl_pkg::ADDR_ACCEL, vpl_pkg::RST_ACCEL);
		rchk(vpl_pkg::ADDR_DECEL, vpl_pkg::RST_DECEL);
		rchk(vpl_pkg::ADDR_SCURVE, 32'(vpl_pkg::RST_SCURVE));
		rchk(vpl_pkg::ADDR_LIMIT, 32'(vpl_pkg::RST_LIMIT));
		rchk(vpl_pkg::ADDR_MASK, 32'h0);
		rchk(vpl_pkg::ADDR_MODE, 32'h0);
		rchk(16'h2209, 32'h0);
		$display("test reset values done");
		rd(vpl_pkg::ADDR_STATUS, d);
		wr(vpl_pkg::ADDR_MASK, 32'h4);
		for (int i = 0; i < 7; i++) begin
			wr(bad_a[i], bad_v[i]);
			rchk(bad_a[i], keep_v[i]);
		end
		chk1(irq, 1'b1);
		rd(vpl_pkg::ADDR_STATUS, d);
		chk32(d, 32'h4);
		#1;
		chk1(irq, 1'b0);
		wr(vpl_pkg::ADDR_LIMIT, 32'h1770);
		rchk(vpl_pkg::ADDR_LIMIT, 32'h1770);
		wr(vpl_pkg::ADDR_SCURVE, 32'h1388);
		rchk(vpl_pkg::ADDR_SCURVE, 32'h1388);
		wr(vpl_pkg::ADDR_DECEL, 32'h7fff_ffff);
		rchk(vpl_pkg::ADDR_DECEL, 32'h7fff_ffff);
		wr(vpl_pkg::ADDR_MODE, 32'hff);
		rchk(vpl_pkg::ADDR_MODE, 32'h1);
		$display("test ranges done");
		@(posedge clk);
		motor_sel <= '{load: 1'b1, max_speed: 16'd3000};
		@(posedge clk);
		motor_sel <= '{load: 1'b1, max_speed: 16'd7000};
		@(posedge clk);
		motor_sel <= '0;
		rchk(vpl_pkg::ADDR_LIMIT, 32'h0bb8);
		$display("test motor load done");
		wr(vpl_pkg::ADDR_MODE, 32'h0);
		wr(vpl_pkg::ADDR_ACCEL, ACC);
		wr(vpl_pkg::ADDR_DECEL, DEC);
		wr(vpl_pkg::ADDR_SCURVE, 32'h0);
		wr(vpl_pkg::ADDR_LIMIT, 32'd500);
		repeat (400) @(posedge clk);
		cmd_level <= 16'sd1000;
		follow(1000, 1'b1);
		cmd_level <= 16'sh0000;
		follow(0, 1'b1);
		$display("test linear ramp done");
		wr(vpl_pkg::ADDR_MODE, 32'h1);
		cmd_level <= 16'sd1000;
		follow(500, 1'b1);
		repeat (5 * CT) @(posedge clk);
		#1;
		chk16(speed_ref, 16'sd500);
		chk1(seq_out_vlimit, 1'b1);
		rd(vpl_pkg::ADDR_STATUS, d);
		wr(vpl_pkg::ADDR_MASK, 32'h1);
		cmd_level <= -16'sd1000;
		follow(-500, 1'b1);
		pins(16'sh0000);
		chk1(seq_out_vlimit, 1'b1);
		chk1(irq, 1'b1);
		rchk(vpl_pkg::ADDR_REF, 32'hffff_fe0c);
		rd(vpl_pkg::ADDR_STATUS, d);
		chk32(d, 32'h3);
		#1;
		chk1(irq, 1'b0);
		ovr_en <= 1'b1;
		pins(16'sd499);
		chk1(seq_out_vlimit, 1'b0);
		pins(-16'sd600);
		chk1(seq_out_vlimit, 1'b1);
		cmd_level <= 16'sh0000;
		follow(0, 1'b1);
		wr(vpl_pkg::ADDR_MODE, 32'h0);
		pins(-16'sd600);
		chk1(seq_out_vlimit, 1'b0);
		ovr_en <= 1'b0;
		$display("test limit done");
		wr(vpl_pkg::ADDR_LIMIT, 32'h1770);
		wr(vpl_pkg::ADDR_SCURVE, 32'h1);
		repeat (600) @(posedge clk);
		cmd_level <= 16'sd1000;
		follow(1000, 1'b0);
		chk1(first_step < 161, 1'b1);
		chk1(max_step <= 161, 1'b1);
		chk1(n_cyc > 8 * CT, 1'b1);
		wr(vpl_pkg::ADDR_SCURVE, 32'h0);
		cmd_level <= 16'sh0000;
		follow(0, 1'b0);
		$display("test s-curve done");
		wrap_up();
	end
endmodule : velocity_profile_limiter_tb
